//--- design/dual_dac_control.sv
// Register file and conversion control for a two-channel 8-bit converter
// What this block does
// - Two 8-bit read/write channel code registers
// - Code registers clear on reset and standby
// - Control register becomes 0x1F on reset, standby
// - Bit 7 enables channel 1 conversion and output
// - Bit 6 enables channel 0 conversion and output
// - Bit 5 joins conversion of both channels
// - Both enables clear stops all conversion
// - Pin drive follows own enable bit, gated off by standby
// - Control bits 4..0 read as one
// - Standby register 0xFE on reset, hardware standby
// - Bit 0 keeps output alive in software standby
// - Standby bits 7..1 read as one
// - Two channels convert independently
// - Enabled channel converts; write restarts conversion
// - Output level equals code over 256 times reference
// - Output persists until rewrite or disable
// - Enable makes pin output, clear makes input
// - Standby enable keeps registers through software standby
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module dual_dac_control (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// Power state from the chip's power controller
	input wire logic sw_standby,
	input wire logic hw_standby,
	// Avalon-MM slave
	input wire logic [dac_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Analog section, one per channel
	output dac_pkg::chan_out_t analog_out_ch0,
	output dac_pkg::chan_out_t analog_out_ch1
);

	function automatic logic reg_hit(input logic [dac_pkg::ADDR_W-1:0] addr,
		input logic [1:0] idx);
		reg_hit = (addr == {idx, 2'b00});
	endfunction

	logic [7:0] code_reg [2];
	logic ch1_output_enable;
	logic ch0_output_enable;
	logic joint_conversion_enable;
	logic standby_output_enable;
	logic ack_reg;
	logic req;
	logic wr_acc;
	logic rd_acc;
	logic clr_regs;
	logic out_off;
	logic [7:0] ctrl_view;
	logic [7:0] stby_view;
	logic [1:0] oe;
	logic [1:0] conv_en;
	logic [1:0] conv_en_prev_reg;
	logic [1:0] wr_code;
	dac_pkg::chan_state_t st_reg [2];
	logic [dac_pkg::CONV_CNT_W-1:0] cnt_reg [2];
	logic [7:0] level_reg [2];

	// One wait state: data are registered, and the master samples a stable answer
	assign req = avs_read | avs_write;
	// Clock enable low holds the answer back, else a write would be acknowledged and lost
	assign avs_waitrequest = req & ~(ack_reg & ce);
	assign wr_acc = avs_write & ack_reg & ce;
	assign rd_acc = avs_read & ~ack_reg & ce;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack_reg <= 1'b0;
		end else if (ce) begin
			ack_reg <= req & ~ack_reg;
		end
	end

	// Software standby without the keep bit behaves as a register reset
	assign clr_regs = hw_standby | (sw_standby & ~standby_output_enable);
	assign out_off = hw_standby | (sw_standby & ~standby_output_enable);

	generate
		for (genvar i = 0; i < 2; i++) begin : g_code
			assign wr_code[i] = wr_acc & avs_byteenable[0] &
				reg_hit(avs_address, 2'(i));
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					code_reg[i] <= dac_pkg::CODE_RESET;
				end else if (ce) begin
					if (clr_regs) begin
						code_reg[i] <= dac_pkg::CODE_RESET;
					end else if (wr_code[i]) begin
						code_reg[i] <= avs_writedata[7:0];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ch1_output_enable <= dac_pkg::CONTROL_RESET[dac_pkg::CTRL_OE1_BIT];
			ch0_output_enable <= dac_pkg::CONTROL_RESET[dac_pkg::CTRL_OE0_BIT];
			joint_conversion_enable <= dac_pkg::CONTROL_RESET[dac_pkg::CTRL_JOINT_BIT];
		end else if (ce) begin
			if (clr_regs) begin
				ch1_output_enable <= dac_pkg::CONTROL_RESET[dac_pkg::CTRL_OE1_BIT];
				ch0_output_enable <= dac_pkg::CONTROL_RESET[dac_pkg::CTRL_OE0_BIT];
				joint_conversion_enable <= dac_pkg::CONTROL_RESET[dac_pkg::CTRL_JOINT_BIT];
			end else if (wr_acc && avs_byteenable[0] &&
				reg_hit(avs_address, dac_pkg::IDX_CONTROL)) begin
				ch1_output_enable <= avs_writedata[dac_pkg::CTRL_OE1_BIT];
				ch0_output_enable <= avs_writedata[dac_pkg::CTRL_OE0_BIT];
				joint_conversion_enable <= avs_writedata[dac_pkg::CTRL_JOINT_BIT];
			end
		end
	end

	// Only hardware standby resets the keep bit; software standby leaves it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			standby_output_enable <= dac_pkg::STANDBY_RESET[dac_pkg::STBY_STE_BIT];
		end else if (ce) begin
			if (hw_standby) begin
				standby_output_enable <= dac_pkg::STANDBY_RESET[dac_pkg::STBY_STE_BIT];
			end else if (wr_acc && avs_byteenable[0] &&
				reg_hit(avs_address, dac_pkg::IDX_STANDBY)) begin
				standby_output_enable <= avs_writedata[dac_pkg::STBY_STE_BIT];
			end
		end
	end

	assign ctrl_view = {ch1_output_enable, ch0_output_enable, joint_conversion_enable,
		dac_pkg::CTRL_RSVD_ONES};
	assign stby_view = {dac_pkg::STBY_RSVD_ONES, standby_output_enable};

	// Read data captured in the wait cycle, shown while waitrequest is low
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_acc) begin
			if (reg_hit(avs_address, dac_pkg::IDX_CODE_CH0)) begin
				avs_readdata <= {24'h00_0000, code_reg[0]};
			end else if (reg_hit(avs_address, dac_pkg::IDX_CODE_CH1)) begin
				avs_readdata <= {24'h00_0000, code_reg[1]};
			end else if (reg_hit(avs_address, dac_pkg::IDX_CONTROL)) begin
				avs_readdata <= {24'h00_0000, ctrl_view};
			end else if (reg_hit(avs_address, dac_pkg::IDX_STANDBY)) begin
				avs_readdata <= {24'h00_0000, stby_view};
			end else begin
				avs_readdata <= 32'h0000_0000;
			end
		end
	end

	// Joint mode lets either enable start both; none set stops both
	assign oe = {ch1_output_enable, ch0_output_enable};
	assign conv_en[0] = oe[0] | (joint_conversion_enable & oe[1]);
	assign conv_en[1] = oe[1] | (joint_conversion_enable & oe[0]);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			conv_en_prev_reg <= 2'b00;
		end else if (ce) begin
			conv_en_prev_reg <= conv_en;
		end
	end

	generate
		for (genvar i = 0; i < 2; i++) begin : g_chan
			// Each channel has its own timer and result; neither waits on the other
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					st_reg[i] <= dac_pkg::CH_IDLE;
					cnt_reg[i] <= '0;
				end else if (ce) begin
					if (!conv_en[i]) begin
						st_reg[i] <= dac_pkg::CH_IDLE;
						cnt_reg[i] <= '0;
					end else if (!conv_en_prev_reg[i] || wr_code[i]) begin
						st_reg[i] <= dac_pkg::CH_BUSY;
						cnt_reg[i] <= dac_pkg::CONV_LAST;
					end else begin
						case (st_reg[i])
							dac_pkg::CH_IDLE: begin
								st_reg[i] <= dac_pkg::CH_IDLE;
							end
							dac_pkg::CH_BUSY: begin
								if (cnt_reg[i] == '0) begin
									st_reg[i] <= dac_pkg::CH_DONE;
								end else begin
									cnt_reg[i] <= cnt_reg[i] - 1'b1;
								end
							end
							dac_pkg::CH_DONE: begin
								st_reg[i] <= dac_pkg::CH_DONE;
							end
							default: begin
								st_reg[i] <= dac_pkg::CH_IDLE;
							end
						endcase
					end
				end
			end

			// Result code held for the analog stage: level = code / 256 * Vref
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					level_reg[i] <= dac_pkg::CODE_RESET;
				end else if (ce && conv_en[i] && st_reg[i] == dac_pkg::CH_BUSY &&
					cnt_reg[i] == '0 && !wr_code[i]) begin
					level_reg[i] <= code_reg[i];
				end
			end
		end
	endgenerate

	// Pin direction follows the channel's own enable, gated off by standby, never the joint bit
	always_comb begin
		analog_out_ch0.drive = oe[0] & ~out_off;
		analog_out_ch0.converting = conv_en[0];
		analog_out_ch0.valid = oe[0] & (st_reg[0] == dac_pkg::CH_DONE);
		analog_out_ch0.level = level_reg[0];
		analog_out_ch1.drive = oe[1] & ~out_off;
		analog_out_ch1.converting = conv_en[1];
		analog_out_ch1.valid = oe[1] & (st_reg[1] == dac_pkg::CH_DONE);
		analog_out_ch1.level = level_reg[1];
	end

	// Checks
	sequence s_req_waiting;
		(avs_read || avs_write) && avs_waitrequest && ce;
	endsequence

	sequence s_answered;
		!avs_waitrequest || !(avs_read || avs_write) || !ce;
	endsequence

	a_wait_one_cycle: assert property (@(posedge clk_sys) disable iff (rst)
		s_req_waiting |=> s_answered)
		else $error("waitrequest held beyond one cycle");

	a_ctrl_rsvd_ones: assert property (@(posedge clk_sys) disable iff (rst)
		avs_read && !avs_waitrequest && reg_hit(avs_address, dac_pkg::IDX_CONTROL)
		|-> avs_readdata[4:0] == 5'h1F && avs_readdata[31:8] == 24'h00_0000)
		else $error("control read lost reserved ones");

	a_stby_rsvd_ones: assert property (@(posedge clk_sys) disable iff (rst)
		avs_read && !avs_waitrequest && reg_hit(avs_address, dac_pkg::IDX_STANDBY)
		|-> avs_readdata[7:1] == 7'h7F)
		else $error("standby read lost reserved ones");

	a_hw_stby_clear: assert property (@(posedge clk_sys) disable iff (rst)
		hw_standby && ce |=> code_reg[0] == 8'h00 && code_reg[1] == 8'h00 &&
		!standby_output_enable && ctrl_view == 8'h1F)
		else $error("hardware standby did not clear registers");

	a_sw_stby_keep: assert property (@(posedge clk_sys) disable iff (rst)
		sw_standby && !hw_standby && standby_output_enable && ce && !wr_acc
		|=> $stable(code_reg[0]) && $stable(code_reg[1]) && $stable(ctrl_view))
		else $error("registers changed in software standby");

	a_both_off_idle: assert property (@(posedge clk_sys) disable iff (rst)
		!ch0_output_enable && !ch1_output_enable && ce
		|=> st_reg[0] == dac_pkg::CH_IDLE && st_reg[1] == dac_pkg::CH_IDLE)
		else $error("conversion ran with both enables clear");

	a_drive_own_bit: assert property (@(posedge clk_sys) disable iff (rst)
		$changed(joint_conversion_enable) && $stable(oe) && $stable(out_off)
		|-> $stable(analog_out_ch0.drive) && $stable(analog_out_ch1.drive))
		else $error("pin drive followed the joint bit");

	a_write_restarts: assert property (@(posedge clk_sys) disable iff (rst)
		wr_code[0] && conv_en[0] |=> st_reg[0] == dac_pkg::CH_BUSY &&
		cnt_reg[0] == dac_pkg::CONV_LAST)
		else $error("code write did not restart conversion");

	a_valid_after_time: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(st_reg[0] == dac_pkg::CH_DONE) |-> $past(cnt_reg[0]) == '0 &&
		level_reg[0] == code_reg[0])
		else $error("channel 0 valid before conversion time");

	a_joint_both: assert property (@(posedge clk_sys) disable iff (rst)
		joint_conversion_enable && (ch0_output_enable || ch1_output_enable)
		|-> analog_out_ch0.converting && analog_out_ch1.converting)
		else $error("joint mode left a channel idle");

	a_ce_holds_wait: assert property (@(posedge clk_sys) disable iff (rst)
		(avs_read || avs_write) && !ce |-> avs_waitrequest)
		else $error("answer given while clock enable low");

	a_code_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
		wr_code[1] && !clr_regs |=> code_reg[1] == $past(avs_writedata[7:0]))
		else $error("channel 1 code write lost");

	a_ctrl_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
		wr_acc && avs_byteenable[0] && reg_hit(avs_address, dac_pkg::IDX_CONTROL) &&
		!clr_regs |=> ctrl_view[7:5] == $past(avs_writedata[7:5]))
		else $error("control write lost");

	a_stby_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
		wr_acc && avs_byteenable[0] && reg_hit(avs_address, dac_pkg::IDX_STANDBY) &&
		!hw_standby |=> standby_output_enable == $past(avs_writedata[0]))
		else $error("standby write lost");

	a_sw_stby_bit_kept: assert property (@(posedge clk_sys) disable iff (rst)
		sw_standby && !hw_standby && ce && !wr_acc |=> $stable(standby_output_enable))
		else $error("software standby changed the keep bit");

	a_sw_stby_clear: assert property (@(posedge clk_sys) disable iff (rst)
		sw_standby && !standby_output_enable && ce |=>
		code_reg[0] == dac_pkg::CODE_RESET && code_reg[1] == dac_pkg::CODE_RESET &&
		ctrl_view == dac_pkg::CONTROL_RESET)
		else $error("software standby without keep bit left registers set");

	a_stby_drive_off: assert property (@(posedge clk_sys) disable iff (rst)
		hw_standby || (sw_standby && !standby_output_enable)
		|-> !analog_out_ch0.drive && !analog_out_ch1.drive)
		else $error("pin driven in standby without keep bit");

	a_restart_ch1: assert property (@(posedge clk_sys) disable iff (rst)
		wr_code[1] && conv_en[1] |=> st_reg[1] == dac_pkg::CH_BUSY &&
		cnt_reg[1] == dac_pkg::CONV_LAST)
		else $error("channel 1 code write did not restart conversion");

	a_valid_time_ch1: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(st_reg[1] == dac_pkg::CH_DONE) |-> $past(cnt_reg[1]) == '0 &&
		level_reg[1] == code_reg[1])
		else $error("channel 1 valid before conversion time");

	a_timer_counts_down: assert property (@(posedge clk_sys) disable iff (rst)
		st_reg[0] == dac_pkg::CH_BUSY && cnt_reg[0] != '0 && conv_en[0] &&
		conv_en_prev_reg[0] && !wr_code[0] && ce |=> cnt_reg[0] == $past(cnt_reg[0]) - 1'b1)
		else $error("channel 0 timer skipped a cycle");

	// A finished result stays on the pin until a rewrite or a cleared enable
	sequence s_ch0_result;
		analog_out_ch0.valid && !wr_code[0];
	endsequence

	sequence s_ch0_kept;
		!ch0_output_enable || (analog_out_ch0.valid && $stable(analog_out_ch0.level));
	endsequence

	a_result_persists: assert property (@(posedge clk_sys) disable iff (rst)
		s_ch0_result |=> s_ch0_kept)
		else $error("channel 0 result dropped without cause");

	a_rd_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
		avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");

	a_code_rd_match: assert property (@(posedge clk_sys) disable iff (rst)
		avs_read && !avs_waitrequest && $past(ce) &&
		reg_hit(avs_address, dac_pkg::IDX_CODE_CH0)
		|-> avs_readdata[7:0] == $past(code_reg[0]))
		else $error("channel 0 code read mismatch");

	a_joint_off_single: assert property (@(posedge clk_sys) disable iff (rst)
		!joint_conversion_enable && ch0_output_enable && !ch1_output_enable
		|-> analog_out_ch0.converting && !analog_out_ch1.converting)
		else $error("channel 1 converted without its enable or the joint bit");

endmodule

`default_nettype wire

//--- design/dac_pkg.sv
// Constants and carrier types for the two-channel converter control block
package dac_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [1:0] IDX_CODE_CH0 = 2'h0;
	localparam logic [1:0] IDX_CODE_CH1 = 2'h1;
	localparam logic [1:0] IDX_CONTROL = 2'h2;
	localparam logic [1:0] IDX_STANDBY = 2'h3;
	localparam int ADDR_W = 4;

	// Values after reset
	localparam logic [7:0] CODE_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h1F;
	localparam logic [7:0] STANDBY_RESET = 8'hFE;

	// Field positions
	localparam int CTRL_OE1_BIT = 7;
	localparam int CTRL_OE0_BIT = 6;
	localparam int CTRL_JOINT_BIT = 5;
	localparam int STBY_STE_BIT = 0;
	localparam logic [4:0] CTRL_RSVD_ONES = 5'h1F;
	localparam logic [6:0] STBY_RSVD_ONES = 7'h7F;

	// Conversion time, longest figure rounded down to whole cycles
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_TIME_NS = 10000;
	localparam int CONV_CYCLES_INT = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int CONV_CNT_W = 10;
	localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES_INT - 1);

	// Per-channel view toward the analog section
	typedef struct packed {
		logic drive;
		logic converting;
		logic valid;
		logic [7:0] level;
	} chan_out_t;

	// Per-channel conversion timer
	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_BUSY = 2'b01,
		CH_DONE = 2'b10
	} chan_state_t;
endpackage

//--- verification/dual_dac_control_tb.sv
// Self-checking bench for the two-channel converter control block
`timescale 1ns/1ps
`default_nettype none

module dual_dac_control_tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic sw_standby = 1'b0;
	logic hw_standby = 1'b0;
	logic [dac_pkg::ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	dac_pkg::chan_out_t analog_out_ch0;
	dac_pkg::chan_out_t analog_out_ch1;
	int n_mismatch = 0;
	int comparisons = 0;
	int n;
	logic [7:0] rv;
	logic [7:0] c;

	dual_dac_control i_dut (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.sw_standby(sw_standby),
		.hw_standby(hw_standby),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.analog_out_ch0(analog_out_ch0),
		.analog_out_ch1(analog_out_ch1)
	);

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic summarize();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkb(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask

	// One idle edge first, so a release and a new request never share a time step
	task automatic bus(input logic is_wr, input logic [3:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= is_wr;
		avs_read <= ~is_wr;
		// Values read here are those that stand just before this edge
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [1:0] i, input logic [7:0] d);
		bus(1'b1, {i, 2'b00}, d, rv);
	endtask

	task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00, rv);
		chk(what, exp, rv);
	endtask

	task automatic conv_wait(input bit ch, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk_sys);
			cnt++;
			#1;
		end while ((ch ? analog_out_ch1.valid : analog_out_ch0.valid) !== 1'b1 && cnt < 1100);
	endtask

	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		rd_chk("code0 reset", 4'h0, 8'h00);
		rd_chk("code1 reset", 4'h4, 8'h00);
		rd_chk("control reset", 4'h8, 8'h1F);
		rd_chk("standby reset", 4'hC, 8'hFE);
		rd_chk("unmapped", 4'h1, 8'h00);
		wr(dac_pkg::IDX_CODE_CH0, 8'hA5);
		wr(dac_pkg::IDX_CODE_CH1, 8'h3C);
		rd_chk("code0", 4'h0, 8'hA5);
		rd_chk("code1", 4'h4, 8'h3C);
		wr(dac_pkg::IDX_CONTROL, 8'h00);
		rd_chk("control rsvd", 4'h8, 8'h1F);
		wr(dac_pkg::IDX_STANDBY, 8'h00);
		rd_chk("standby rsvd", 4'hC, 8'hFE);
		avs_byteenable <= 4'h0;
		wr(dac_pkg::IDX_CODE_CH0, 8'hFF);
		avs_byteenable <= 4'hF;
		rd_chk("lane off", 4'h0, 8'hA5);
		// Clock enable drops while the answer is due; the write must wait for it
		fork
			wr(dac_pkg::IDX_CODE_CH1, 8'h11);
			begin
				repeat (2) @(posedge clk_sys);
				ce <= 1'b0;
				repeat (3) @(posedge clk_sys);
				chkb("wait under ce low", 1'b1, avs_waitrequest);
				ce <= 1'b1;
			end
		join
		rd_chk("code1 after ce", 4'h4, 8'h11);
		for (int k = 0; k < 8; k++) begin
			c = {k[2:0], 5'h00};
			wr(dac_pkg::IDX_CONTROL, c);
			#1;
			chkb("drive0", c[6], analog_out_ch0.drive);
			chkb("drive1", c[7], analog_out_ch1.drive);
			chkb("conv0", c[6] | (c[5] & c[7]), analog_out_ch0.converting);
			chkb("conv1", c[7] | (c[5] & c[6]), analog_out_ch1.converting);
			rd_chk("control", 4'h8, c | 8'h1F);
		end
		// Stop both channels first so that the next enable starts a fresh conversion
		wr(dac_pkg::IDX_CONTROL, 8'h00);
		#1;
		chkb("conv0 stopped", 1'b0, analog_out_ch0.converting);
		wr(dac_pkg::IDX_CONTROL, 8'h40);
		conv_wait(1'b0, n);
		chkb("conv time", 1'b1, n == dac_pkg::CONV_CYCLES_INT + 1);
		chk("level0", 8'hA5, analog_out_ch0.level);
		chkb("ch1 idle", 1'b0, analog_out_ch1.converting);
		wr(dac_pkg::IDX_CODE_CH0, 8'h5A);
		@(posedge clk_sys);
		#1;
		chkb("valid restart", 1'b0, analog_out_ch0.valid);
		chk("level held", 8'hA5, analog_out_ch0.level);
		// The restart check above already spent one edge of the conversion
		conv_wait(1'b0, n);
		chkb("conv time rewrite", 1'b1, n == dac_pkg::CONV_CYCLES_INT - 1);
		chk("level0 new", 8'h5A, analog_out_ch0.level);
		wr(dac_pkg::IDX_CONTROL, 8'h80);
		#1;
		chkb("valid cleared", 1'b0, analog_out_ch0.valid);
		chkb("ch1 alone", 1'b1, analog_out_ch1.converting);
		// Standby bit still 0: software standby clears codes and control
		@(posedge clk_sys);
		sw_standby <= 1'b1;
		rd_chk("code0 sw stby", 4'h0, 8'h00);
		rd_chk("control sw stby", 4'h8, 8'h1F);
		chkb("drive1 sw stby", 1'b0, analog_out_ch1.drive);
		rd_chk("standby kept", 4'hC, 8'hFE);
		sw_standby <= 1'b0;
		wr(dac_pkg::IDX_STANDBY, 8'h01);
		rd_chk("standby bit", 4'hC, 8'hFF);
		wr(dac_pkg::IDX_CODE_CH1, 8'h77);
		wr(dac_pkg::IDX_CONTROL, 8'h80);
		sw_standby <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		chkb("drive1 kept", 1'b1, analog_out_ch1.drive);
		rd_chk("code1 kept", 4'h4, 8'h77);
		rd_chk("control kept", 4'h8, 8'h9F);
		conv_wait(1'b1, n);
		chkb("valid1 kept", 1'b1, analog_out_ch1.valid);
		chk("level1 kept", 8'h77, analog_out_ch1.level);
		hw_standby <= 1'b1;
		rd_chk("standby hw", 4'hC, 8'hFE);
		rd_chk("code1 hw", 4'h4, 8'h00);
		chkb("drive1 hw", 1'b0, analog_out_ch1.drive);
		hw_standby <= 1'b0;
		sw_standby <= 1'b0;
		wr(dac_pkg::IDX_STANDBY, 8'h01);
		// Mid-run reset must bring back the reset values
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd_chk("standby rst", 4'hC, 8'hFE);
		chk("level1 rst", 8'h00, analog_out_ch1.level);
		summarize();
	end

	// Whole run is near 3200 cycles; over six times that means a hang
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		$display("CHECK FAILED watchdog expected done seen timeout");
		summarize();
	end
endmodule
`default_nettype wire
